// *** sbw_pkg.sv ***
// Constants and helper functions for the sector buffer status writer.
// Assumes a byte-wide buffer RAM cut into fixed segments, one per block.
//
// Contract
// - Packed count is mantissa times four to exponent
// - Resolution steps 1, 4, 16, 64 by range
// - Subcode field written only by copy channel
// - Copy walks interleaved order, raw or de-interleaved
// - Raw mode does not separate the Q field
// - Corrector status stored twice; equal means unwritten
// - Block status kept until segment refilled
// - Corrector offers single-pass and check-only modes
// - Multi-block transfers run without processor help
// - Unchanged reload values loop same buffer area
// - DVD blocks use other sizes; corrector flags invalid
// - Sub-CPU reads buffer memory directly
// - Input logic writes offsets up to count byte; tail also writes both corrector markers in CD mode
// - Each block fills exactly one 2560-byte segment
package sbw_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 25;
  localparam int          SEG_W        = 13;
  localparam logic [11:0] SEG_BYTES    = 12'hA00;  // 2560
  localparam logic [11:0] CD_DATA_SIZE = 12'h930;  // 2352
  localparam logic [11:0] DVD_DATA_SIZE = 12'h810; // 2064
  localparam logic [11:0] OFS_STAT0    = 12'h930;  // 2352
  localparam logic [11:0] OFS_CNT      = 12'h933;  // 2355
  localparam logic [11:0] DVD_OFS_CNT  = 12'h813;
  localparam logic [11:0] OFS_RW       = 12'h934;  // 2356
  localparam logic [11:0] OFS_Q        = 12'h994;  // 2452
  localparam logic [11:0] OFS_ECC_A    = 12'h9A1;  // 2465
  localparam logic [11:0] OFS_ECC_B    = 12'h9A2;  // 2466
  localparam logic [11:0] CNT_MAX      = 12'hFFF;

  // ---------------------------------------------------------------
  // Subcode holding buffer walk: 12 groups of one Q and 8 R-W bytes
  // ---------------------------------------------------------------
  localparam logic [3:0]  SUB_GROUPS   = 4'hC;
  localparam logic [3:0]  SUB_GRP_LEN  = 4'h9;
  localparam logic [6:0]  RAW_LEN      = 7'h60;    // 96

  // Byte address of an offset inside a segment
  function automatic logic [ADDR_W-1:0] sbw_addr(
    input logic [SEG_W-1:0] seg,
    input logic [11:0]      ofs);
    sbw_addr = ADDR_W'(seg) * ADDR_W'(SEG_BYTES) + ADDR_W'(ofs);
  endfunction

  // Compress a 12-bit count to exponent[7:6], mantissa[5:0]
  function automatic logic [7:0] sbw_pack(input logic [11:0] n);
    if (n < 12'h040) begin
      sbw_pack = {2'b00, n[5:0]};
    end else if (n < 12'h100) begin
      sbw_pack = {2'b01, n[7:2]};
    end else if (n < 12'h400) begin
      sbw_pack = {2'b10, n[9:4]};
    end else begin
      sbw_pack = {2'b11, n[11:6]};
    end
  endfunction

endpackage

// *** sbw_cnt_if.sv ***
// Link between the block sequencer and the erasure flag counter.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface sbw_cnt_if;
  logic       clr;
  logic       flag;
  logic [7:0] cnt_byte;
  modport ctl (output clr, output flag, input cnt_byte);
  modport cnt (input clr, input flag, output cnt_byte);
endinterface

// *** sbw_erasure_pack.sv ***
// Erasure flag counter with packed one-byte result.
// Assumes clr and flag are single-cycle strobes on mclk.
`timescale 1ns/10ps
module sbw_erasure_pack
  import sbw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  sbw_cnt_if.cnt   cif
);

  logic [11:0] count_ff;
  logic [11:0] nxt_count;

  // ---------------------------------------------------------------
  // Counter; a flag on the first byte counts into the new block
  // ---------------------------------------------------------------
  always_comb begin
    nxt_count = count_ff;
    if (cif.clr) begin
      nxt_count = cif.flag ? 12'h001 : 12'h000;
    end else if (cif.flag && count_ff != CNT_MAX) begin
      nxt_count = count_ff + 12'h001; // Saturates at 12 bits
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_ff <= 12'h000;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign cif.cnt_byte = sbw_pack(count_ff);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_pack_small;
    @(posedge mclk) disable iff (rst)
    (count_ff < 12'h040) |-> (cif.cnt_byte == {2'b00, count_ff[5:0]});
  endproperty
  a_pack_small: assert property (p_pack_small)
    else $error("small count not stored exactly");

  property p_pack_big;
    @(posedge mclk) disable iff (rst)
    (count_ff >= 12'h400) |-> (cif.cnt_byte == {2'b11, count_ff[11:6]});
  endproperty
  a_pack_big: assert property (p_pack_big)
    else $error("large count packing wrong");

  property p_clear;
    @(posedge mclk) disable iff (rst)
    (cif.clr && !cif.flag) |=> (count_ff == 12'h000);
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter not cleared at block start");

endmodule // sbw_erasure_pack

// *** sbw_writer.sv ***
// Sector buffer status writer: places block data, status copies,
// packed erasure count, subcode and corrector status into segments.
// Assumes all inputs come from logic on mclk, stream bytes at most
// every second cycle, and a RAM answering reads one cycle later.
`timescale 1ns/10ps
module sbw_writer
  import sbw_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              in_valid,
  input  wire logic              in_sof,
  input  wire logic [7:0]        in_byte,
  input  wire logic              in_erasure,
  input  wire logic [23:0]       stat_in,
  input  wire logic              dvd_mode,
  input  wire logic              sub_en,
  input  wire logic              sub_raw,
  input  wire logic              sub_valid,
  input  wire logic [SEG_W-1:0]  sub_seg,
  input  wire logic [7:0]        sub_byte,
  output logic                   sub_ready_ff,
  input  wire logic              ecc_en,
  input  wire logic              ecc_valid,
  input  wire logic [SEG_W-1:0]  ecc_seg,
  input  wire logic [7:0]        ecc_stat,
  output logic                   ecc_ready_ff,
  input  wire logic              ecc_onepass,
  input  wire logic              ecc_edc_only,
  output logic [1:0]             erc_mode_ff,
  input  wire logic              xfer_start,
  input  wire logic              seg_inc_en,
  input  wire logic              seg_wr_dis,
  input  wire logic [SEG_W-1:0]  next_seg,
  input  wire logic [7:0]        next_cnt,
  output logic [SEG_W-1:0]       cur_seg_ff,
  output logic [7:0]             cur_cnt_ff,
  output logic [SEG_W-1:0]       prev_seg_ff,
  output logic                   reload_irq_ff,
  input  wire logic              cpu_rd,
  input  wire logic [ADDR_W-1:0] cpu_addr,
  output logic                   cpu_busy_ff,
  output logic [7:0]             cpu_rdata_ff,
  output logic                   cpu_rvalid_ff,
  input  wire logic [7:0]        ram_rdata,
  output logic [ADDR_W-1:0]      ram_addr_ff,
  output logic [7:0]             ram_wdata_ff,
  output logic                   ram_we_ff,
  output logic                   ram_re_ff
);

  typedef enum {T_IDLE, T_CAP, T_S0, T_S1, T_S2, T_CNT, T_MA, T_MB}
    sbw_tail_e;

  sbw_cnt_if cif ();

  sbw_erasure_pack u_cnt (
    .mclk (mclk),
    .rst  (rst),
    .cif  (cif.cnt)
  );

  sbw_tail_e        tail_ff, nxt_tail;
  logic [11:0]      ofs_ff, nxt_ofs, wofs, dsize;
  logic [SEG_W-1:0] tail_seg_ff, nxt_tail_seg;
  logic [23:0]      tail_stat_ff, nxt_tail_stat;
  logic [7:0]       tail_pk_ff, nxt_tail_pk;
  logic             tail_wr_ff, nxt_tail_wr;
  logic             active, wr_ok, blk_end;
  logic [1:0]       nxt_erc_mode;
  logic [SEG_W-1:0] nxt_cur_seg, nxt_prev_seg;
  logic [7:0]       nxt_cur_cnt;
  logic             nxt_irq;

  // ---------------------------------------------------------------
  // Stream side: offset tracking and block end
  // ---------------------------------------------------------------
  assign dsize   = dvd_mode ? DVD_DATA_SIZE : CD_DATA_SIZE;
  assign wofs    = in_sof ? 12'h000 : ofs_ff;
  assign active  = (cur_cnt_ff != 8'h00) && !seg_wr_dis;
  assign wr_ok   = in_valid && active && (wofs < dsize);
  assign blk_end = in_valid && (wofs == dsize - 12'h001);
  assign cif.clr  = in_valid && in_sof;
  assign cif.flag = in_valid && in_erasure;

  // ---------------------------------------------------------------
  // Tail sequence: status copies, count byte, corrector markers.
  // The stream owns the port when a byte arrives, so tail steps wait.
  // ---------------------------------------------------------------
  logic g_tail;
  assign g_tail = !wr_ok && tail_ff != T_IDLE && tail_ff != T_CAP;

  always_comb begin
    nxt_tail      = tail_ff;
    nxt_tail_seg  = tail_seg_ff;
    nxt_tail_stat = tail_stat_ff;
    nxt_tail_pk   = tail_pk_ff;
    nxt_tail_wr   = tail_wr_ff;
    nxt_ofs       = in_valid ? wofs + 12'h001 : ofs_ff;
    if (blk_end) begin
      nxt_tail      = T_CAP;
      nxt_tail_seg  = cur_seg_ff;
      nxt_tail_stat = stat_in;
      nxt_tail_wr   = active;
    end else begin
      case (tail_ff)
        T_IDLE: nxt_tail = T_IDLE;
        T_CAP: begin
          // Last flag has landed in the counter one cycle after the end
          nxt_tail_pk = cif.cnt_byte;
          if (!tail_wr_ff) begin
            nxt_tail = T_IDLE;
          end else begin
            nxt_tail = dvd_mode ? T_CNT : T_S0;
          end
        end
        T_S0: nxt_tail = g_tail ? T_S1 : T_S0;
        T_S1: nxt_tail = g_tail ? T_S2 : T_S1;
        T_S2: nxt_tail = g_tail ? T_CNT : T_S2;
        T_CNT: begin
          if (g_tail) begin
            nxt_tail = dvd_mode ? T_IDLE : T_MA;
          end
        end
        T_MA: nxt_tail = g_tail ? T_MB : T_MA;
        T_MB: nxt_tail = g_tail ? T_IDLE : T_MB;
        default: nxt_tail = T_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Segment pointers: advance per block, reload when count runs out
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cur_seg  = cur_seg_ff;
    nxt_cur_cnt  = cur_cnt_ff;
    nxt_prev_seg = prev_seg_ff;
    nxt_irq      = 1'b0;
    nxt_erc_mode = erc_mode_ff;
    if (cif.clr) begin
      nxt_erc_mode = {ecc_edc_only, ecc_onepass};
    end
    if (blk_end && cur_cnt_ff != 8'h00) begin
      nxt_prev_seg = cur_seg_ff;
      if (cur_cnt_ff == 8'h01) begin
        // Same reload values give the same area again
        nxt_cur_seg = next_seg;
        nxt_cur_cnt = next_cnt;
        nxt_irq     = 1'b1;
      end else begin
        nxt_cur_cnt = cur_cnt_ff - 8'h01;
        if (seg_inc_en) begin
          nxt_cur_seg = cur_seg_ff + 13'h0001;
        end
      end
    end else if (xfer_start && cur_cnt_ff == 8'h00) begin
      nxt_cur_seg = next_seg;
      nxt_cur_cnt = next_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Subcode copy: walk groups of Q plus eight R-W bytes
  // ---------------------------------------------------------------
  logic [3:0]  grp_ff, pos_ff, nxt_grp, nxt_pos;
  logic        sub_pend_ff, nxt_sub_pend, sub_acc, g_sub;
  logic [11:0] sub_ofs_ff, nxt_sub_ofs;
  logic [SEG_W-1:0] sub_sg_ff, nxt_sub_sg;
  logic [7:0]  sub_dat_ff, nxt_sub_dat;
  logic [6:0]  raw_idx, rw_idx;

  assign sub_acc = sub_en && sub_valid && sub_ready_ff;
  assign raw_idx = 7'(grp_ff * SUB_GRP_LEN) + 7'(pos_ff);
  assign rw_idx  = 7'({grp_ff, 3'b000}) + 7'(pos_ff) - 7'h01;

  always_comb begin
    nxt_grp      = sub_en ? grp_ff : 4'h0;
    nxt_pos      = sub_en ? pos_ff : 4'h0;
    nxt_sub_pend = sub_pend_ff && !g_sub;
    nxt_sub_ofs  = sub_ofs_ff;
    nxt_sub_sg   = sub_sg_ff;
    nxt_sub_dat  = sub_dat_ff;
    if (sub_acc) begin
      // Interleaved walk is used in both modes
      nxt_pos = (pos_ff == SUB_GRP_LEN - 4'h1) ? 4'h0 : pos_ff + 4'h1;
      if (pos_ff == SUB_GRP_LEN - 4'h1) begin
        nxt_grp = (grp_ff == SUB_GROUPS - 4'h1) ? 4'h0 : grp_ff + 4'h1;
      end
      nxt_sub_sg  = sub_seg;
      nxt_sub_dat = sub_byte;
      if (sub_raw) begin
        // Q bytes stay where they sit among the raw bytes
        nxt_sub_pend = raw_idx < RAW_LEN;
        nxt_sub_ofs  = OFS_RW + 12'(raw_idx);
      end else begin
        nxt_sub_pend = 1'b1;
        nxt_sub_ofs  = (pos_ff == 4'h0) ? OFS_Q + 12'(grp_ff)
                                        : OFS_RW + 12'(rw_idx);
      end
    end
  end

  // ---------------------------------------------------------------
  // Corrector status: value then its inverse, so equal bytes can
  // only mean the corrector never wrote this block
  // ---------------------------------------------------------------
  logic [1:0]       ecc_ph_ff, nxt_ecc_ph;
  logic [7:0]       ecc_dat_ff, nxt_ecc_dat;
  logic [SEG_W-1:0] ecc_sg_ff, nxt_ecc_sg;
  logic             ecc_acc, g_ecc;

  assign ecc_acc = ecc_en && ecc_valid && ecc_ready_ff && !dvd_mode;

  always_comb begin
    nxt_ecc_ph  = ecc_ph_ff;
    nxt_ecc_dat = ecc_dat_ff;
    nxt_ecc_sg  = ecc_sg_ff;
    if (ecc_acc) begin
      nxt_ecc_ph  = 2'h1;
      nxt_ecc_dat = ecc_stat;
      nxt_ecc_sg  = ecc_seg;
    end else if (g_ecc) begin
      nxt_ecc_ph = (ecc_ph_ff == 2'h1) ? 2'h2 : 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // Port arbitration: stream, tail, CPU read, corrector, subcode.
  // Subcode is last as its holding buffer tolerates waiting.
  // ---------------------------------------------------------------
  logic              cpu_pend_ff, nxt_cpu_pend, g_cpu, re_d_ff;
  logic [ADDR_W-1:0] cpu_a_ff, nxt_cpu_a, nxt_addr;
  logic [7:0]        nxt_wdata, nxt_rdata;
  logic              nxt_we;

  assign g_cpu = !wr_ok && !g_tail && cpu_pend_ff;
  assign g_ecc = !wr_ok && !g_tail && !cpu_pend_ff && ecc_ph_ff != 2'h0;
  assign g_sub = !wr_ok && !g_tail && !cpu_pend_ff && ecc_ph_ff == 2'h0
                 && sub_pend_ff;

  always_comb begin
    nxt_cpu_pend = (cpu_pend_ff && !g_cpu) || (cpu_rd && !cpu_busy_ff);
    nxt_cpu_a    = (cpu_rd && !cpu_busy_ff) ? cpu_addr : cpu_a_ff;
    nxt_rdata    = re_d_ff ? ram_rdata : cpu_rdata_ff;
    nxt_we       = wr_ok || g_tail || g_ecc || g_sub;
    nxt_addr     = ram_addr_ff;
    nxt_wdata    = ram_wdata_ff;
    if (wr_ok) begin
      nxt_addr  = sbw_addr(cur_seg_ff, wofs);
      nxt_wdata = in_byte;
    end else if (g_tail) begin
      case (tail_ff)
        T_S0: nxt_addr = sbw_addr(tail_seg_ff, OFS_STAT0);
        T_S1: nxt_addr = sbw_addr(tail_seg_ff, OFS_STAT0 + 12'h001);
        T_S2: nxt_addr = sbw_addr(tail_seg_ff, OFS_STAT0 + 12'h002);
        T_CNT: nxt_addr = sbw_addr(tail_seg_ff,
                                   dvd_mode ? DVD_OFS_CNT : OFS_CNT);
        T_MA: nxt_addr = sbw_addr(tail_seg_ff, OFS_ECC_A);
        default: nxt_addr = sbw_addr(tail_seg_ff, OFS_ECC_B);
      endcase
      case (tail_ff)
        T_S0: nxt_wdata = tail_stat_ff[7:0];
        T_S1: nxt_wdata = tail_stat_ff[15:8];
        T_S2: nxt_wdata = tail_stat_ff[23:16];
        T_CNT: nxt_wdata = tail_pk_ff;
        default: nxt_wdata = 8'h00; // Equal markers until corrected
      endcase
    end else if (g_cpu) begin
      nxt_addr = cpu_a_ff;
    end else if (g_ecc) begin
      nxt_addr  = sbw_addr(ecc_sg_ff,
                           ecc_ph_ff == 2'h1 ? OFS_ECC_A : OFS_ECC_B);
      nxt_wdata = ecc_ph_ff == 2'h1 ? ecc_dat_ff : ~ecc_dat_ff;
    end else if (g_sub) begin
      nxt_addr  = sbw_addr(sub_sg_ff, sub_ofs_ff);
      nxt_wdata = sub_dat_ff;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tail_ff <= T_IDLE;         ofs_ff <= 12'h000;
      tail_seg_ff <= '0;         tail_stat_ff <= 24'h000000;
      tail_pk_ff <= 8'h00;       tail_wr_ff <= 1'b0;
      cur_seg_ff <= '0;          cur_cnt_ff <= 8'h00;
      prev_seg_ff <= '0;         reload_irq_ff <= 1'b0;
      erc_mode_ff <= 2'h0;       grp_ff <= 4'h0;
      pos_ff <= 4'h0;            sub_pend_ff <= 1'b0;
      sub_ofs_ff <= 12'h000;     sub_sg_ff <= '0;
      sub_dat_ff <= 8'h00;       sub_ready_ff <= 1'b0;
      ecc_ph_ff <= 2'h0;         ecc_dat_ff <= 8'h00;
      ecc_sg_ff <= '0;           ecc_ready_ff <= 1'b0;
      cpu_pend_ff <= 1'b0;       cpu_a_ff <= '0;
      cpu_busy_ff <= 1'b0;       re_d_ff <= 1'b0;
      cpu_rdata_ff <= 8'h00;     cpu_rvalid_ff <= 1'b0;
      ram_addr_ff <= '0;         ram_wdata_ff <= 8'h00;
      ram_we_ff <= 1'b0;         ram_re_ff <= 1'b0;
    end else begin
      tail_ff <= nxt_tail;       ofs_ff <= nxt_ofs;
      tail_seg_ff <= nxt_tail_seg; tail_stat_ff <= nxt_tail_stat;
      tail_pk_ff <= nxt_tail_pk; tail_wr_ff <= nxt_tail_wr;
      cur_seg_ff <= nxt_cur_seg; cur_cnt_ff <= nxt_cur_cnt;
      prev_seg_ff <= nxt_prev_seg; reload_irq_ff <= nxt_irq;
      erc_mode_ff <= nxt_erc_mode; grp_ff <= nxt_grp;
      pos_ff <= nxt_pos;         sub_pend_ff <= nxt_sub_pend;
      sub_ofs_ff <= nxt_sub_ofs; sub_sg_ff <= nxt_sub_sg;
      sub_dat_ff <= nxt_sub_dat; sub_ready_ff <= !nxt_sub_pend;
      ecc_ph_ff <= nxt_ecc_ph;   ecc_dat_ff <= nxt_ecc_dat;
      ecc_sg_ff <= nxt_ecc_sg;   ecc_ready_ff <= nxt_ecc_ph == 2'h0;
      cpu_pend_ff <= nxt_cpu_pend; cpu_a_ff <= nxt_cpu_a;
      cpu_busy_ff <= nxt_cpu_pend; re_d_ff <= ram_re_ff;
      cpu_rdata_ff <= nxt_rdata; cpu_rvalid_ff <= re_d_ff;
      ram_addr_ff <= nxt_addr;   ram_wdata_ff <= nxt_wdata;
      ram_we_ff <= nxt_we;       ram_re_ff <= g_cpu;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_ecc_inv;
    @(posedge mclk) disable iff (rst)
    (g_ecc && ecc_ph_ff == 2'h2) |=>
      ram_we_ff && ram_wdata_ff == ~$past(ecc_dat_ff);
  endproperty
  a_ecc_inv: assert property (p_ecc_inv)
    else $error("second status copy not inverted");

  property p_sub_off;
    @(posedge mclk) disable iff (rst)
    (!sub_en && !sub_pend_ff) |=> !sub_pend_ff;
  endproperty
  a_sub_off: assert property (p_sub_off)
    else $error("subcode queued while copy disabled");

  property p_raw_no_q;
    @(posedge mclk) disable iff (rst)
    (sub_acc && sub_raw) |=>
      !sub_pend_ff || (sub_ofs_ff >= OFS_RW && sub_ofs_ff < OFS_Q);
  endproperty
  a_raw_no_q: assert property (p_raw_no_q)
    else $error("raw subcode written to Q field");

  property p_reload;
    @(posedge mclk) disable iff (rst)
    (blk_end && cur_cnt_ff == 8'h01) |=>
      reload_irq_ff && cur_seg_ff == $past(next_seg) ##1 !reload_irq_ff;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload did not take next values");

  property p_advance;
    @(posedge mclk) disable iff (rst)
    (blk_end && cur_cnt_ff > 8'h01 && seg_inc_en) |=>
      cur_seg_ff == $past(cur_seg_ff) + 13'h0001 &&
      cur_cnt_ff == $past(cur_cnt_ff) - 8'h01;
  endproperty
  a_advance: assert property (p_advance)
    else $error("segment did not advance");

  property p_count_byte;
    @(posedge mclk) disable iff (rst)
    (g_tail && tail_ff == T_CNT) |=>
      ram_we_ff && ram_wdata_ff == $past(tail_pk_ff);
  endproperty
  a_count_byte: assert property (p_count_byte)
    else $error("count byte not written");

  property p_stream;
    @(posedge mclk) disable iff (rst)
    wr_ok |=> ram_we_ff && ram_wdata_ff == $past(in_byte);
  endproperty
  a_stream: assert property (p_stream)
    else $error("stream byte not written");

  property p_cpu_rd;
    @(posedge mclk) disable iff (rst)
    (cpu_rd && !cpu_busy_ff) |-> ##[3:30] cpu_rvalid_ff;
  endproperty
  a_cpu_rd: assert property (p_cpu_rd)
    else $error("cpu read not answered");

  c_reload: cover property (@(posedge mclk) disable iff (rst)
    reload_irq_ff);
  c_ecc: cover property (@(posedge mclk) disable iff (rst)
    g_ecc && ecc_ph_ff == 2'h2);
  c_raw: cover property (@(posedge mclk) disable iff (rst)
    sub_acc && sub_raw && pos_ff == 4'h0);
  c_cpu: cover property (@(posedge mclk) disable iff (rst)
    cpu_rvalid_ff);

endmodule // sbw_writer

// *** sbw_ram_model.sv ***
// Behavioural byte-wide buffer RAM on the far side of the writer.
// Assumes one mclk domain and read data one cycle after a read strobe.
`timescale 1ns/10ps
module sbw_ram_model (
  input  wire logic        mclk,
  input  wire logic [24:0] ram_addr_ff,
  input  wire logic [7:0]  ram_wdata_ff,
  input  wire logic        ram_we_ff,
  input  wire logic        ram_re_ff,
  output logic [7:0]       ram_rdata
);
  logic [7:0] mem [int];

  // Unwritten places read as unknown so stale data never passes
  function automatic logic [7:0] rd(input int a);
    rd = mem.exists(a) ? mem[a] : 8'hXX;
  endfunction

  // Writes land at once; idle read bus toggles so no old value lingers
  always @(posedge mclk) begin
    if (ram_we_ff) mem[int'(ram_addr_ff)] = ram_wdata_ff;
    if (ram_re_ff) ram_rdata <= rd(int'(ram_addr_ff));
    else ram_rdata <= ~ram_rdata;
  end
endmodule // sbw_ram_model

// *** tb_top.sv ***
// Self-checking bench for the sector buffer status writer.
// Assumes the RAM model stands in for the external buffer RAM.
`timescale 1ns/10ps
module tb_top;
  import sbw_pkg::*;
  logic mclk = 0, rst = 1, in_valid = 0, in_sof = 0, in_erasure = 0;
  logic [7:0] in_byte = 0, sub_byte = 0, ecc_stat = 0, next_cnt = 0;
  logic [23:0] stat_in = 24'h332211;
  logic dvd_mode = 0, sub_en = 0, sub_raw = 0, sub_valid = 0;
  logic ecc_en = 0, ecc_valid = 0, ecc_onepass = 0, ecc_edc_only = 0;
  logic xfer_start = 0, seg_inc_en = 1, seg_wr_dis = 0, cpu_rd = 0;
  logic [SEG_W-1:0] sub_seg = 0, ecc_seg = 0, next_seg = 0;
  logic [SEG_W-1:0] cur_seg_ff, prev_seg_ff;
  logic [ADDR_W-1:0] cpu_addr = 0, ram_addr_ff;
  logic [7:0] cur_cnt_ff, cpu_rdata_ff, ram_rdata, ram_wdata_ff;
  logic sub_ready_ff, ecc_ready_ff, reload_irq_ff, cpu_busy_ff;
  logic cpu_rvalid_ff, ram_we_ff, ram_re_ff;
  logic [1:0] erc_mode_ff;
  int n_fail = 0, checks_done = 0, n_irq = 0;
  int n_eras [5] = '{5, 63, 64, 257, 1100};
  logic [7:0] exp_cnt [5] = '{8'h05, 8'h3F, 8'h50, 8'h90, 8'hD1};

  always #10 mclk = ~mclk;

  sbw_writer dut (.mclk, .rst, .in_valid, .in_sof, .in_byte, .in_erasure,
    .stat_in, .dvd_mode, .sub_en, .sub_raw, .sub_valid, .sub_seg,
    .sub_byte, .sub_ready_ff, .ecc_en, .ecc_valid, .ecc_seg, .ecc_stat,
    .ecc_ready_ff, .ecc_onepass, .ecc_edc_only, .erc_mode_ff, .xfer_start,
    .seg_inc_en, .seg_wr_dis, .next_seg, .next_cnt, .cur_seg_ff,
    .cur_cnt_ff, .prev_seg_ff, .reload_irq_ff, .cpu_rd, .cpu_addr,
    .cpu_busy_ff, .cpu_rdata_ff, .cpu_rvalid_ff, .ram_rdata, .ram_addr_ff,
    .ram_wdata_ff, .ram_we_ff, .ram_re_ff);
  sbw_ram_model ram (.mclk, .ram_addr_ff, .ram_wdata_ff, .ram_we_ff,
    .ram_re_ff, .ram_rdata);

  // Reload pulses seen on the design's output
  always @(posedge mclk) begin
    if (reload_irq_ff === 1'b1) n_irq++;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One block at the required spacing of one byte every second cycle
  task automatic send_block(input int n);
    for (int i = 0; i < 2352; i++) begin
      @(posedge mclk);
      in_valid <= 1;
      in_sof <= (i == 0);
      in_byte <= i[7:0];
      in_erasure <= (i < n);
      @(posedge mclk);
      in_valid <= 0;
    end
    repeat (20) @(posedge mclk);
  endtask

  // One subcode byte, then time for the low-priority write to land
  task automatic send_sub(input logic [7:0] b);
    sub_byte <= b;
    sub_valid <= 1;
    @(posedge mclk);
    sub_valid <= 0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 0;
    repeat (2) @(posedge mclk);
    chk8(cur_cnt_ff, 8'h00);
    chk8({6'h00, sub_ready_ff, ecc_ready_ff}, 8'h03);
    $display("reset test done");
    next_seg <= 2;
    next_cnt <= 5;
    xfer_start <= 1;
    @(posedge mclk);
    xfer_start <= 0;
    // --------------------------------------------------------------
    // Rows: erasure counts and their packed bytes
    // --------------------------------------------------------------
    foreach (n_eras[k]) begin
      send_block(n_eras[k]);
      chk8(ram.rd((2 + k) * 2560 + 2355), exp_cnt[k]);
      chk8(ram.rd((2 + k) * 2560 + 100), 8'h64);
      chk8(ram.rd((2 + k) * 2560 + 2352), 8'h11);
      chk8(ram.rd((2 + k) * 2560 + 2465),
           ram.rd((2 + k) * 2560 + 2466));
      chk8(8'(prev_seg_ff), 8'(2 + k));
      $display("row %0d done", k);
    end
    // Count ran out on the fifth block: unchanged reload values loop
    chk8(8'(cur_seg_ff), 8'h02);
    chk8(8'(prev_seg_ff), 8'h06);
    chk8(cur_cnt_ff, 8'h05);
    chk8(8'(n_irq), 8'h01);
    // Corrector status lands as a value and its inverse
    ecc_en <= 1;
    ecc_seg <= 2;
    ecc_stat <= 8'h5A;
    ecc_valid <= 1;
    @(posedge mclk);
    ecc_valid <= 0;
    repeat (10) @(posedge mclk);
    chk8(ram.rd(2 * 2560 + 2465), 8'h5A);
    chk8(ram.rd(2 * 2560 + 2466), 8'hA5);
    $display("corrector test done");
    // Sub-CPU read returns what the RAM holds
    cpu_addr <= 25'(3 * 2560 + 2352);
    cpu_rd <= 1;
    @(posedge mclk);
    cpu_rd <= 0;
    for (int w = 0; w < 40 && cpu_rvalid_ff !== 1'b1; w++) @(posedge mclk);
    chk8(cpu_rdata_ff, 8'h11);
    $display("cpu read test done");
    // Disabled copy channel leaves the subcode field alone
    sub_seg <= 4;
    send_sub(8'hC3);
    chk8(ram.rd(4 * 2560 + 2452), 8'hXX);
    // Enabled, de-interleaved: Q byte first, then first R-W byte
    sub_en <= 1;
    @(posedge mclk);
    for (int b = 0; b < 2; b++) send_sub(8'hE0 + 8'(b));
    chk8(ram.rd(4 * 2560 + 2452), 8'hE0);
    chk8(ram.rd(4 * 2560 + 2356), 8'hE1);
    // Raw: walk restarted with copy off keeps its Q byte in place
    sub_en <= 0;
    sub_raw <= 1;
    @(posedge mclk);
    sub_en <= 1;
    send_sub(8'h9C);
    chk8(ram.rd(4 * 2560 + 2356), 8'h9C);
    chk8(ram.rd(4 * 2560 + 2452), 8'hE0);
    $display("subcode test done");
    // DVD block: count byte moved, corrector markers left alone
    sub_en <= 0;
    dvd_mode <= 1;
    ecc_edc_only <= 1;
    send_block(70);
    chk8(ram.rd(2 * 2560 + 2067), 8'h51);
    chk8(ram.rd(2 * 2560 + 2465), 8'h5A);
    chk8(8'(erc_mode_ff), 8'h02);
    $display("dvd test done");
    print_verdict();
  end

  // Watchdog: six blocks need about 29000 cycles
  initial begin
    #(60000 * 20);
    n_fail++;
    print_verdict();
  end
endmodule // tb_top
